// ==== osc_params.svh ====
`ifndef OSC_PARAMS_SVH
`define OSC_PARAMS_SVH
// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define ADDR_RUN_CLOCK_CFG   12'h060
`define ADDR_CHECK_STATUS    12'h064
// ----------------------------------------------------------------------
// run clock configuration fields
// ----------------------------------------------------------------------
`define BIT_POWER_DOWN       13
`define BIT_OUTPUT_ENABLE    12
`define BIT_BYPASS           11
`define BIT_PLL_CHECK        10
`define CRYS_HI              9
`define CRYS_LO              6
`define SRC_HI               5
`define SRC_LO               4
`define BIT_INT_CHECK        3
`define BIT_MAIN_CHECK       2
`define BIT_INT_DIS          1
`define BIT_MAIN_DIS         0
`define CFG_WRITE_MASK       32'h0000_3fff
`define CFG_RESET            32'h0000_3ac0
`define CRYS_RESET           4'hb
`define CRYS_LAST_RESERVED   4'h3
`define SRC_RESERVED         2'h3
// ----------------------------------------------------------------------
// status register bits
// ----------------------------------------------------------------------
`define ST_PLL_FAIL          0
`define ST_MAIN_FAIL         1
`define ST_INT_FAIL          2
`define ST_BAD_WRITE         3
// one verification timer per watched source
`define N_CHECKS             3
// ----------------------------------------------------------------------
// verification timing
// ----------------------------------------------------------------------
`define CHECK_WINDOW_NS      1000
`define CLK_PERIOD_NS        10
`define CHECK_WINDOW_CYC     (`CHECK_WINDOW_NS / `CLK_PERIOD_NS)
`endif

// ==== osc_pkg.sv ====
package osc_pkg;
  // oscillator source codes
  typedef enum logic [1:0] {
    SRC_MAIN      = 2'h0,
    SRC_INTERNAL  = 2'h1,
    SRC_INT_DIV4  = 2'h2,
    SRC_RESV      = 2'h3
  } osc_source_e;
  // pll operating mode
  typedef enum logic [1:0] {
    PLL_POWERED_DOWN = 2'h0,
    PLL_NORMAL       = 2'h1,
    PLL_HELD         = 2'h2
  } pll_mode_e;
endpackage

// ==== activity_checker.sv ====
`include "osc_params.svh"
// watches a clock-activity toggle; flags failure when no edge arrives
// within the window while enabled
module activity_checker #(
  parameter int WINDOW = `CHECK_WINDOW_CYC
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // control
  input  wire logic check_enable,
  input  wire logic activity_toggle,
  // result
  output logic      fail_pulse
);
  import osc_pkg::*;

  initial begin
    // the cycle counter is 16 bits wide
    if (WINDOW < 2 || WINDOW > 65536) $error("activity window out of range");
  end

  logic [15:0] count_reg, count_next;
  logic        sync1_reg, sync2_reg, last_reg;
  logic        fail_reg, fail_next;

  // ----------------------------------------------------------------------
  // count cycles since the last toggle edge
  // ----------------------------------------------------------------------
  always_comb begin
    count_next = count_reg;
    fail_next  = 1'b0;
    if (!check_enable || (sync2_reg != last_reg)) begin
      count_next = 16'h0000;
    end else if (count_reg == 16'(WINDOW - 1)) begin
      count_next = 16'h0000;
      fail_next  = 1'b1;  // restart so a dead source keeps reporting
    end else begin
      count_next = count_reg + 16'h0001;
    end
  end

  // sync first flop only feeds the second
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count_reg <= 16'h0000;
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg  <= 1'b0;
      fail_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      sync1_reg <= activity_toggle;
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
      fail_reg  <= fail_next;
    end
  end

  assign fail_pulse = fail_reg;

  property p_no_fail_disabled;
    @(posedge ref_clk) disable iff (sys_rst)
      !check_enable |=> !fail_pulse;
  endproperty
  a_no_fail_disabled: assert property (p_no_fail_disabled)
    else $error("checker failed while disabled");
endmodule

// ==== apb_slave_port.sv ====
`include "osc_params.svh"
// apb handshake: zero wait state, one-cycle write strobe, slverr on
// unmapped address
module apb_slave_port (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  output logic             pready,
  output logic             pslverr,
  // decoded access
  output logic             wr_cfg,
  output logic             wr_status,
  output logic             rd_sel_status,
  output logic             access_now
);
  import osc_pkg::*;

  logic mapped;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  always_comb begin
    mapped        = (paddr == `ADDR_RUN_CLOCK_CFG) ||
                    (paddr == `ADDR_CHECK_STATUS);
    access_now    = psel && penable;
    pready        = psel && penable;  // no wait states
    pslverr       = access_now && !mapped;
    wr_cfg        = access_now && pwrite && (paddr == `ADDR_RUN_CLOCK_CFG);
    wr_status     = access_now && pwrite && (paddr == `ADDR_CHECK_STATUS);
    rd_sel_status = (paddr == `ADDR_CHECK_STATUS);
  end
endmodule

// ==== osc_clock_control.sv ====
`include "osc_params.svh"
// Summary of operation
// RULE_01: pll check bit set runs pll timer, failure raises interrupt
// RULE_02: crystal code field bits 9..6, resets to code 0xb
// RULE_03: crystal codes 0..3 reserved; writes of them are refused
// RULE_04: source field bits 5..4; 00 main, 01 int, 10 int/4, 11 reserved
// RULE_05: internal oscillator check bit runs timer, failure interrupts
// RULE_06: main oscillator check bit runs timer, failure interrupts
// RULE_07: main oscillator disable 1 stops it, 0 keeps running
// RULE_08: power-down 1 forces power down; both clear gives normal mode
// RULE_09: internal oscillator disable bit 1 stops it, 0 runs
// RULE_10: failure interrupts are sticky levels until software clears
// RULE_11: pll power-down resets to 1
// RULE_12: bypass picks oscillator source, else divided pll output
module osc_clock_control #(
  parameter int CHECK_WINDOW = `CHECK_WINDOW_CYC
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // activity toggles from the clock sources
  input  wire logic        pll_activity,
  input  wire logic        main_osc_activity,
  input  wire logic        int_osc_activity,
  // oscillator and pll controls
  output logic             main_osc_enable,
  output logic             int_osc_enable,
  output osc_pkg::osc_source_e osc_source,
  output logic [3:0]       crystal_code,
  output logic             pll_power_down_out,
  output logic             pll_output_enable_n,
  output osc_pkg::pll_mode_e pll_mode,
  output logic             sysclk_from_pll,
  // failure requests
  output logic             pll_fail_irq,
  output logic             main_osc_fail_irq,
  output logic             int_osc_fail_irq
);
  import osc_pkg::*;

  initial begin
    if (CHECK_WINDOW < 2) $error("check window too short");
  end

  logic [31:0] cfg_reg, cfg_next;
  logic [3:0]  status_reg, status_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        wr_cfg, wr_status, rd_sel_status, access_now;
  logic        pll_fail, main_fail, int_fail;
  logic [`N_CHECKS-1:0] chk_en, chk_act, chk_fail;
  logic [3:0]  wdata_crys;
  logic [1:0]  wdata_src;
  logic        bad_write;

  // ----------------------------------------------------------------------
  // bus port and verification timers
  // ----------------------------------------------------------------------
  apb_slave_port u_bus (
    .ref_clk       (ref_clk),
    .sys_rst       (sys_rst),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pready        (pready),
    .pslverr       (pslverr),
    .wr_cfg        (wr_cfg),
    .wr_status     (wr_status),
    .rd_sel_status (rd_sel_status),
    .access_now    (access_now)
  );

  // timer lanes are indexed like the status bits they feed
  always_comb begin
    chk_en                 = 3'h0;
    chk_act                = 3'h0;
    chk_en[`ST_PLL_FAIL]   = cfg_reg[`BIT_PLL_CHECK];  // see RULE_01
    chk_en[`ST_MAIN_FAIL]  = cfg_reg[`BIT_MAIN_CHECK];  // see RULE_06
    chk_en[`ST_INT_FAIL]   = cfg_reg[`BIT_INT_CHECK];  // see RULE_05
    chk_act[`ST_PLL_FAIL]  = pll_activity;
    chk_act[`ST_MAIN_FAIL] = main_osc_activity;
    chk_act[`ST_INT_FAIL]  = int_osc_activity;
    pll_fail               = chk_fail[`ST_PLL_FAIL];
    main_fail              = chk_fail[`ST_MAIN_FAIL];
    int_fail               = chk_fail[`ST_INT_FAIL];
  end

  for (genvar g = 0; g < `N_CHECKS; g++) begin : g_chk
    activity_checker #(.WINDOW(CHECK_WINDOW)) u_chk (
      .ref_clk         (ref_clk),
      .sys_rst         (sys_rst),
      .check_enable    (chk_en[g]),
      .activity_toggle (chk_act[g]),
      .fail_pulse      (chk_fail[g])
    );
  end

  // ----------------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------------
  // reserved codes keep the old field value rather than mislead the pll
  always_comb begin
    wdata_crys = pwdata[`CRYS_HI:`CRYS_LO];
    wdata_src  = pwdata[`SRC_HI:`SRC_LO];
    bad_write  = wr_cfg && ((wdata_crys <= `CRYS_LAST_RESERVED) ||
                            (wdata_src == `SRC_RESERVED));
    cfg_next   = cfg_reg;
    if (wr_cfg) begin
      cfg_next = pwdata & `CFG_WRITE_MASK;
      if (wdata_crys <= `CRYS_LAST_RESERVED) begin  // see RULE_03
        cfg_next[`CRYS_HI:`CRYS_LO] = cfg_reg[`CRYS_HI:`CRYS_LO];
      end
      if (wdata_src == `SRC_RESERVED) begin  // see RULE_04
        cfg_next[`SRC_HI:`SRC_LO] = cfg_reg[`SRC_HI:`SRC_LO];
      end
    end
  end

  // ----------------------------------------------------------------------
  // sticky failure status, write one to clear, set beats clear
  // ----------------------------------------------------------------------
  always_comb begin
    status_next = status_reg;
    if (wr_status) begin
      status_next = status_reg & ~pwdata[3:0];
    end
    if (pll_fail) status_next[`ST_PLL_FAIL] = 1'b1;  // see RULE_10
    if (main_fail) status_next[`ST_MAIN_FAIL] = 1'b1;
    if (int_fail) status_next[`ST_INT_FAIL] = 1'b1;
    if (bad_write) status_next[`ST_BAD_WRITE] = 1'b1;
  end

  // ----------------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------------
  always_comb begin
    prdata_next = prdata_reg;
    if (psel && !penable) begin
      prdata_next = rd_sel_status ? {28'h0000000, status_reg} : cfg_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_reg    <= `CFG_RESET;  // see RULE_02
      status_reg <= 4'h0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      cfg_reg    <= cfg_next;
      status_reg <= status_next;
      prdata_reg <= prdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------------
  always_comb begin
    prdata              = prdata_reg;
    main_osc_enable     = !cfg_reg[`BIT_MAIN_DIS];  // see RULE_07
    int_osc_enable      = !cfg_reg[`BIT_INT_DIS];  // see RULE_09
    osc_source          = osc_source_e'(cfg_reg[`SRC_HI:`SRC_LO]);
    crystal_code        = cfg_reg[`CRYS_HI:`CRYS_LO];
    pll_power_down_out  = cfg_reg[`BIT_POWER_DOWN];  // see RULE_11
    pll_output_enable_n = cfg_reg[`BIT_OUTPUT_ENABLE];
    sysclk_from_pll     = !cfg_reg[`BIT_BYPASS];  // see RULE_12
    if (cfg_reg[`BIT_POWER_DOWN]) begin
      pll_mode = PLL_POWERED_DOWN;  // see RULE_08
    end else if (!cfg_reg[`BIT_OUTPUT_ENABLE]) begin
      pll_mode = PLL_NORMAL;
    end else begin
      pll_mode = PLL_HELD;
    end
    pll_fail_irq      = status_reg[`ST_PLL_FAIL];
    main_osc_fail_irq = status_reg[`ST_MAIN_FAIL];
    int_osc_fail_irq  = status_reg[`ST_INT_FAIL];
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_fail_sets_irq;
    @(posedge ref_clk) disable iff (sys_rst)
      pll_fail |=> pll_fail_irq;
  endproperty
  a_fail_sets_irq: assert property (p_fail_sets_irq) // see RULE_01
    else $error("pll failure not flagged");

  property p_crys_reserved;
    @(posedge ref_clk) disable iff (sys_rst)
      crystal_code > `CRYS_LAST_RESERVED;
  endproperty
  a_crys_reserved: assert property (p_crys_reserved) // see RULE_03
    else $error("reserved crystal code held");

  property p_src_reserved;
    @(posedge ref_clk) disable iff (sys_rst)
      osc_source != SRC_RESV;
  endproperty
  a_src_reserved: assert property (p_src_reserved) // see RULE_04
    else $error("reserved source held");

  property p_main_fail;
    @(posedge ref_clk) disable iff (sys_rst)
      main_fail |=> main_osc_fail_irq;
  endproperty
  a_main_fail: assert property (p_main_fail) // see RULE_06
    else $error("main failure not flagged");

  property p_int_fail;
    @(posedge ref_clk) disable iff (sys_rst)
      int_fail |=> int_osc_fail_irq;
  endproperty
  a_int_fail: assert property (p_int_fail) // see RULE_05
    else $error("internal failure not flagged");

  property p_main_dis;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_cfg |=> (main_osc_enable == !$past(pwdata[`BIT_MAIN_DIS]));
  endproperty
  a_main_dis: assert property (p_main_dis) // see RULE_07
    else $error("main disable not applied");

  property p_int_dis;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_cfg |=> (int_osc_enable == !$past(pwdata[`BIT_INT_DIS]));
  endproperty
  a_int_dis: assert property (p_int_dis) // see RULE_09
    else $error("internal disable not applied");

  property p_pll_mode;
    @(posedge ref_clk) disable iff (sys_rst)
      pll_power_down_out |-> pll_mode == PLL_POWERED_DOWN;
  endproperty
  a_pll_mode: assert property (p_pll_mode) // see RULE_08
    else $error("pll mode wrong");

  sequence s_irq_up;
    pll_fail_irq && !wr_status;
  endsequence
  property p_irq_sticky;
    @(posedge ref_clk) disable iff (sys_rst)
      s_irq_up |=> pll_fail_irq;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) // see RULE_10
    else $error("failure request dropped");

  property p_reset_pd;
    @(posedge ref_clk) $fell(sys_rst) |-> pll_power_down_out &&
      crystal_code == `CRYS_RESET;
  endproperty
  a_reset_pd: assert property (p_reset_pd) // see RULE_11
    else $error("reset values wrong");

  property p_bypass;
    @(posedge ref_clk) disable iff (sys_rst)
      sysclk_from_pll != cfg_reg[`BIT_BYPASS];
  endproperty
  a_bypass: assert property (p_bypass) // see RULE_12
    else $error("bypass select wrong");

  property p_bad_write_flag;
    @(posedge ref_clk) disable iff (sys_rst)
      bad_write |=> status_reg[`ST_BAD_WRITE];
  endproperty
  a_bad_write_flag: assert property (p_bad_write_flag) // see RULE_03
    else $error("refused write not flagged");

  // a refused code must leave the stored crystal code alone
  sequence s_crys_refused;
    wr_cfg && (wdata_crys <= `CRYS_LAST_RESERVED);
  endsequence
  property p_crys_keep;
    @(posedge ref_clk) disable iff (sys_rst)
      s_crys_refused |=> $stable(crystal_code);
  endproperty
  a_crys_keep: assert property (p_crys_keep) // see RULE_03
    else $error("reserved crystal code stored");

  property p_crys_write;
    @(posedge ref_clk) disable iff (sys_rst)
      (wr_cfg && (wdata_crys > `CRYS_LAST_RESERVED)) |=>
        (crystal_code == $past(wdata_crys));
  endproperty
  a_crys_write: assert property (p_crys_write) // see RULE_02
    else $error("crystal code not stored");

  property p_pll_normal;
    @(posedge ref_clk) disable iff (sys_rst)
      (!pll_power_down_out && !pll_output_enable_n) |->
        (pll_mode == PLL_NORMAL);
  endproperty
  a_pll_normal: assert property (p_pll_normal) // see RULE_08
    else $error("pll not in normal mode");

  property p_int_timer_off;
    @(posedge ref_clk) disable iff (sys_rst)
      !chk_en[`ST_INT_FAIL] |=> !int_fail;
  endproperty
  a_int_timer_off: assert property (p_int_timer_off) // see RULE_05
    else $error("internal timer ran while disabled");

  property p_main_sticky;
    @(posedge ref_clk) disable iff (sys_rst)
      (main_osc_fail_irq && !wr_status) |=> main_osc_fail_irq;
  endproperty
  a_main_sticky: assert property (p_main_sticky) // see RULE_10
    else $error("main failure request dropped");
endmodule

// ==== tb_top.sv ====
`include "osc_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import osc_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic              ref_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [2:0]        act = 3'h0;
  logic [2:0]        run = 3'h7;
  logic              main_osc_enable;
  logic              int_osc_enable;
  osc_source_e       osc_source;
  logic [3:0]        crystal_code;
  logic              pll_power_down_out;
  logic              pll_output_enable_n;
  pll_mode_e         pll_mode;
  logic              sysclk_from_pll;
  logic [2:0]        irq;
  logic [31:0]       sh;
  logic [31:0]       q;
  logic              e;
  int                n_fail = 0;
  int                samples_checked = 0;
  int                cb[3] = '{10, 2, 3};

  // short window keeps the failure tests quick
  osc_clock_control #(.CHECK_WINDOW(8)) u_dut (
    .ref_clk             (ref_clk),
    .sys_rst             (sys_rst),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .pll_activity        (act[0]),
    .main_osc_activity   (act[1]),
    .int_osc_activity    (act[2]),
    .main_osc_enable     (main_osc_enable),
    .int_osc_enable      (int_osc_enable),
    .osc_source          (osc_source),
    .crystal_code        (crystal_code),
    .pll_power_down_out  (pll_power_down_out),
    .pll_output_enable_n (pll_output_enable_n),
    .pll_mode            (pll_mode),
    .sysclk_from_pll     (sysclk_from_pll),
    .pll_fail_irq        (irq[0]),
    .main_osc_fail_irq   (irq[1]),
    .int_osc_fail_irq    (irq[2])
  );

  // ----------------------------------------------------------------
  // clock and source activity
  // ----------------------------------------------------------------
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // a stopped source simply stops toggling
  always @(posedge ref_clk) begin
    act <= act ^ run;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // compare every control output with the expected register image
  task automatic chk_out();
    @(negedge ref_clk);
    check("main_en", main_osc_enable, !sh[0]);
    check("int_en", int_osc_enable, !sh[1]);
    check("source", osc_source, sh[5:4]);
    check("crystal", crystal_code, sh[9:6]);
    check("pd", pll_power_down_out, sh[13]);
    check("out_en_n", pll_output_enable_n, sh[12]);
    check("mode", 32'(pll_mode), sh[13] ? 32'(PLL_POWERED_DOWN) :
          sh[12] ? 32'(PLL_HELD) : 32'(PLL_NORMAL));
    check("from_pll", sysclk_from_pll, !sh[11]);
    apb(1'b0, `ADDR_RUN_CLOCK_CFG, 32'h0);
    check("cfg", q, sh);
  endtask

  // reserved crystal and source codes leave their fields unchanged
  task automatic wcfg(input logic [31:0] w);
    logic bad;
    bad = (w[9:6] < 4'h4) || (w[5:4] == 2'h3);
    apb(1'b1, `ADDR_RUN_CLOCK_CFG, w);
    check("err", e, 1'b0);
    sh[13:10] = w[13:10];
    sh[3:0]   = w[3:0];
    if (w[9:6] >= 4'h4) sh[9:6] = w[9:6];
    if (w[5:4] != 2'h3) sh[5:4] = w[5:4];
    chk_out();
    apb(1'b0, `ADDR_CHECK_STATUS, 32'h0);
    check("refused", q[3], bad);
    if (bad) apb(1'b1, `ADDR_CHECK_STATUS, 32'h8);
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    run     <= 3'h7;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    sh = 32'h0000_3ac0;
    chk_out();
    check("irqs", irq, 3'h0);
  endtask

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    summarize();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    for (int s = 0; s < 4; s++) begin
      wcfg(32'h0000_3ac0 | (s << 4));
    end
    for (int x = 0; x < 16; x++) begin
      wcfg(32'h0000_3800 | (x << 6));
    end
    wcfg(32'h0000_0ac3);
    wcfg(32'h0000_12c2);
    wcfg(32'h0000_2ac1);
    wcfg(32'hffff_c2c0);
    // unmapped address is refused and has no effect
    apb(1'b1, 12'h068, 32'h0000_0003);
    check("bad_wr", e, 1'b1);
    apb(1'b0, 12'h068, 32'h0);
    check("bad_rd", e, 1'b1);
    chk_out();
    // a second reset in mid-run must restore every field
    @(posedge ref_clk);
    do_reset();
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      run <= 3'h7 & ~(3'h1 << i);
      repeat (30) @(posedge ref_clk);
      // outputs are looked at mid-cycle, where they have settled
      @(negedge ref_clk);
      check("irq_off", irq[i], 1'b0);
      wcfg(sh | (32'h1 << cb[i]));
      for (int k = 0; k < 16 && irq[i] !== 1'b1; k++) @(negedge ref_clk);
      check("irq_on", irq[i], 1'b1);
      @(posedge ref_clk);
      run <= 3'h7;
      repeat (20) @(posedge ref_clk);
      @(negedge ref_clk);
      check("sticky", irq[i], 1'b1);
      apb(1'b0, `ADDR_CHECK_STATUS, 32'h0);
      check("status", q[i], 1'b1);
      apb(1'b1, `ADDR_CHECK_STATUS, 32'h1 << i);
      repeat (20) @(posedge ref_clk);
      @(negedge ref_clk);
      check("cleared", irq[i], 1'b0);
      wcfg(sh & ~(32'h1 << cb[i]));
    end
    summarize();
  end
endmodule
